// ===== tb/ssv_chk.sv
// Purpose: port assertions of the security supervisor
// Assumes: single clock, async active-high reset
// Notes:   bound to every ssv_top instance at the foot
`timescale 1ns/10ps
`default_nettype none
module ssv_chk #(
  parameter int AW = 16, // cpu address width
  parameter int NP = 4   // memory partitions
) (
  input wire logic          clk,        // core clock
  input wire logic          rst,        // async reset
  input wire logic [6:0]    det_evt,    // detector levels
  input wire logic          pad_rst,    // raw reset pad
  input wire logic          reg_rd,     // read strobe
  input wire logic          cpu_priv,   // privilege level
  input wire logic [15:0]   reg_rdata,  // read data
  input wire logic          bus_req,    // bus access
  input wire logic [AW-1:0] bus_addr,   // plain address
  input wire logic          mem_en,     // access passed on
  input wire logic          fiq,        // fast interrupt
  input wire logic          chip_rst,   // chip reset request
  input wire logic          rst_pad_f,  // filtered reset pad
  input wire logic          nv_locked,  // stored lock bit
  input wire logic          nv_lock_wr, // burn pulse
  input wire logic          tst_valid,  // tester strobe
  input wire logic [15:0]   tst_data,   // tester word
  input wire logic          test_mode   // test functions open
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic pwd_seen_reg; // password went by since reset
  ////////////////////////////////////////////////////////////////////
  // remembers the password so a test-mode rise can be traced to it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pwd_seen_reg <= 1'b0;
    else if (tst_valid && tst_data == ssv_pkg::TEST_PWD)
      pwd_seen_reg <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (
    !$past(reg_rd && cpu_priv) |-> reg_rdata == 16'h0000)
    else $error("read data without a privileged read");
  a_env_reset: assert property (
    det_evt[0] || det_evt[1] || det_evt[2] || det_evt[6] |=> chip_rst)
    else $error("environment event without chip reset");
  a_trap_invalid: assert property (
    bus_req && bus_addr[AW-1 -: 3] == 3'h7 |=> fiq && !mem_en)
    else $error("invalid address not trapped");
  a_mem_cause: assert property (
    !$past(bus_req) |-> !mem_en)
    else $error("memory enable without a bus request");
  a_burn_pulse: assert property (
    nv_lock_wr |=> !nv_lock_wr)
    else $error("lock burn longer than one cycle");
  a_lock_drop: assert property (
    nv_lock_wr |-> ##[0:1] !test_mode)
    else $error("test mode kept after lock burn");
  a_locked_shut: assert property (
    nv_locked |-> !$rose(test_mode))
    else $error("test mode opened on a locked part");
  a_pwd_first: assert property (
    $rose(test_mode) |-> pwd_seen_reg)
    else $error("test mode opened without password");
  a_rst_filt: assert property (
    $rose(rst_pad_f) |-> $past(pad_rst, 3) && $past(pad_rst, 4))
    else $error("short reset pad pulse passed filter");
endmodule
bind ssv_top ssv_chk #(.AW(AW), .NP(NP)) u_chk (
  .clk(clk), .rst(rst), .det_evt(det_evt), .pad_rst(pad_rst),
  .reg_rd(reg_rd), .cpu_priv(cpu_priv), .reg_rdata(reg_rdata),
  .bus_req(bus_req), .bus_addr(bus_addr), .mem_en(mem_en),
  .fiq(fiq), .chip_rst(chip_rst), .rst_pad_f(rst_pad_f),
  .nv_locked(nv_locked), .nv_lock_wr(nv_lock_wr),
  .tst_valid(tst_valid), .tst_data(tst_data), .test_mode(test_mode)
);
`default_nettype wire

// ===== tb/ssv_tester.sv
// Purpose: manufacturing tester and lock storage model
// Assumes: login is an opener word then the password word
// Notes:   idle data line toggles so stale words never match
`timescale 1ns/10ps
`default_nettype none
module ssv_tester (
  input  wire logic        clk,        // core clock
  input  wire logic        rst,        // async reset
  input  wire logic        start,      // begin one login
  input  wire logic [15:0] pwd,        // password to offer
  input  wire logic        nv_lock_wr, // burn request
  output var logic         nv_locked,  // stored lock bit
  output var logic         tst_valid,  // word strobe
  output var logic  [15:0] tst_data    // word on the line
);
  logic [1:0] step_reg; // 0 idle, 1 opener sent, 2 password sent
  initial nv_locked = 1'b0; // fresh part, never burnt
  ////////////////////////////////////////////////////////////////////
  // storage survives rst; only a burn sets it, nothing clears it
  always @(posedge clk)
  begin
    if (nv_lock_wr)
      nv_locked <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////
  // login: opener, then password, then the line is let go
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      step_reg  <= 2'h0;
      tst_valid <= 1'b0;
      tst_data  <= 16'h0000;
    end
    else
    begin
      step_reg  <= (step_reg == 2'h0) ? {1'b0, start} :
                   (step_reg == 2'h1) ? 2'h2 : 2'h0;
      tst_valid <= (step_reg == 2'h0 && start) || step_reg == 2'h1;
      tst_data  <= (step_reg == 2'h0 && start) ? 16'h00C1 :
                   (step_reg == 2'h1) ? pwd : ~tst_data;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_ssv_top.sv
// Purpose: self-checking bench for the security supervisor
// Assumes: 20 MHz clock, tester model on the test port
// Notes:   register defaults run from a row table first
`timescale 1ns/10ps
`default_nettype none
module tb_ssv_top;
  typedef struct packed {
    logic [3:0]  a;  // register index
    logic        w;  // write first
    logic [15:0] wd; // write data
    logic [15:0] e;  // expected read
  } ssv_row_s;
  logic        clk = 1'b0;       // core clock
  logic        rst = 1'b1;       // async reset
  logic [6:0]  det_evt = 7'h00;  // detector levels
  logic [2:0]  pc_cnt = 3'h0;    // slow pad clock divider
  logic        pad_rst = 1'b0;   // raw reset pad
  logic [3:0]  reg_addr = 4'h0;  // register index
  logic [15:0] reg_wdata = 16'h0000; // write data
  logic        reg_wr = 1'b0;    // write strobe
  logic        reg_rd = 1'b0;    // read strobe
  logic        cpu_priv = 1'b1;  // privilege level
  logic        bus_req = 1'b0;   // bus access
  logic        bus_fetch = 1'b0; // fetch marker
  logic        bus_write = 1'b0; // write marker
  logic [15:0] bus_addr = 16'h0000; // plain address
  logic        start = 1'b0;     // begin a login
  logic [15:0] pwd = 16'h0000;   // password offered
  logic [15:0] reg_rdata, tst_data, mem_addr, t; // observed and scratch
  logic mem_en, fiq, chip_rst, clk_pad_f, rst_pad_f, c;
  logic nv_locked, nv_lock_wr, tst_valid, test_mode;
  int fail_count = 0; // mismatches
  int compares = 0;   // comparisons
  ssv_row_s rows [11] = '{
    '{4'h1, 1'b0, 16'h0000, 16'h004F}, '{4'h0, 1'b0, 16'h0000, 16'h0000},
    '{4'h2, 1'b0, 16'h0000, 16'h0000}, '{4'h4, 1'b0, 16'h0000, 16'h0000},
    '{4'h7, 1'b0, 16'h0000, 16'h0000}, '{4'h9, 1'b0, 16'h0000, 16'h0000},
    '{4'h8, 1'b0, 16'h0000, 16'h0000}, '{4'h9, 1'b1, 16'h1234, 16'h0000},
    '{4'h5, 1'b1, 16'h0007, 16'h0007}, '{4'h1, 1'b1, 16'h0003, 16'h0003},
    '{4'h3, 1'b1, 16'hFFFF, 16'h0000}};
  ////////////////////////////////////////////////////////////////////
  ssv_top u_dut (
    .clk(clk), .rst(rst), .det_evt(det_evt), .pad_clk(pc_cnt[2]),
    .pad_rst(pad_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .cpu_priv(cpu_priv),
    .reg_rdata(reg_rdata), .bus_req(bus_req), .bus_fetch(bus_fetch),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(16'h3C3C),
    .mem_addr(mem_addr), .mem_wdata(), .mem_en(mem_en), .fiq(fiq),
    .chip_rst(chip_rst), .clk_pad_f(clk_pad_f), .rst_pad_f(rst_pad_f),
    .clk_slow(), .cur_noise(), .wait_ins(), .nv_locked(nv_locked),
    .nv_lock_wr(nv_lock_wr), .tst_valid(tst_valid),
    .tst_data(tst_data), .test_mode(test_mode));
  ssv_tester u_tst (
    .clk(clk), .rst(rst), .start(start), .pwd(pwd),
    .nv_lock_wr(nv_lock_wr), .nv_locked(nv_locked),
    .tst_valid(tst_valid), .tst_data(tst_data));
  ////////////////////////////////////////////////////////////////////
  always #25 clk = ~clk;
  // pad clock at an eighth of the core rate, slow enough to pass
  always @(posedge clk) pc_cnt <= pc_cnt + 3'h1;
  task automatic chk(input string nm, input logic [15:0] s, e);
    compares++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(input string nm, input logic [3:0] a, logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(nm, d, e);
  endtask
  task automatic bus(input logic [15:0] a);
    @(posedge clk);
    bus_addr <= a;
    bus_req <= 1'b1;
    @(posedge clk);
    bus_req <= 1'b0;
    #1;
  endtask
  task automatic do_rst(input int n);
    @(posedge clk);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // fixed wait: a refused login gives no completion to wait on
  task automatic login;
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    #500000;
    fail_count++;
    test_done;
  end
  initial
  begin
    do_rst(16);
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].wd);
      rc("reg_row", rows[i].a, rows[i].e);
    end
    $display("register rows done");
    for (int k = 0; k < 2; k++)
      for (int i = 0; i < 7; i++)
      begin
        do_rst(2);
        wr(4'h1, (k == 1) ? 16'h007F : 16'h0000);
        @(posedge clk) det_evt <= 7'h01 << i;
        @(posedge clk) det_evt <= 7'h00;
        // reaction outputs are registered off the event level, so look one edge after it
        #1 c = (k == 1) || (i < 3) || (i == 6);
        chk("chip_rst", {15'h0000, chip_rst}, {15'h0000, c});
        chk("tamper_fiq", {15'h0000, fiq}, {15'h0000, !c});
        rc("det_stat", 4'h0, 16'h0001 << i);
      end
    rc("det_hold", 4'h0, 16'h0040);
    wr(4'h0, 16'h0040);
    rc("det_clear", 4'h0, 16'h0000);
    $display("detector test done");
    do_rst(2);
    @(posedge clk) cpu_priv <= 1'b0;
    wr(4'h1, 16'h0000);
    rc("user_read", 4'h1, 16'h0000);
    @(posedge clk) cpu_priv <= 1'b1;
    rc("react", 4'h1, 16'h004F);
    rc("viol_priv", 4'h2, 16'h0008);
    wr(4'h2, 16'h000F);
    @(posedge clk) cpu_priv <= 1'b0;
    bus(16'hE000);
    chk("trap_en", {15'h0000, mem_en}, 16'h0000);
    chk("trap_fiq", {15'h0000, fiq}, 16'h0001);
    bus(16'h0010);
    chk("prohib", {15'h0000, mem_en}, 16'h0000);
    @(posedge clk) cpu_priv <= 1'b1;
    rc("viol", 4'h2, 16'h0005);
    wr(4'h4, 16'h0001);
    @(posedge clk) cpu_priv <= 1'b0;
    bus(16'h0010);
    chk("granted", {15'h0000, mem_en}, 16'h0001);
    chk("scramble", mem_addr, 16'h0010 ^ ssv_pkg::SCR_KEY_RST);
    @(posedge clk) bus_fetch <= 1'b1;
    bus(16'h0010);
    chk("fetch_fiq", {15'h0000, fiq}, 16'h0001);
    chk("fetch_en", {15'h0000, mem_en}, 16'h0000);
    @(posedge clk) {bus_fetch, bus_write} <= 2'b01;
    bus(16'h0010);
    chk("user_wr", {15'h0000, mem_en}, 16'h0000);
    @(posedge clk) {bus_write, cpu_priv} <= 2'b01;
    $display("access test done");
    @(posedge clk) pad_rst <= 1'b1;
    @(posedge clk) pad_rst <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("rst_glitch", {15'h0000, rst_pad_f}, 16'h0000);
    @(posedge clk) pad_rst <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk("rst_pad_f", {15'h0000, rst_pad_f}, 16'h0001);
    @(posedge clk) pad_rst <= 1'b0;
    #1 c = clk_pad_f;
    repeat (4) @(posedge clk);
    #1 chk("clk_pad_f", {15'h0000, clk_pad_f}, {15'h0000, ~c});
    $display("filter test done");
    do_rst(2);
    pwd <= 16'h1111;
    login;
    chk("bad_pwd", {15'h0000, test_mode}, 16'h0000);
    pwd <= ssv_pkg::TEST_PWD;
    login;
    chk("test_on", {15'h0000, test_mode}, 16'h0001);
    wr(4'hA, 16'h0BEE);
    rc("trace", 4'hA, 16'h0BEE);
    wr(4'h8, 16'h0001);
    repeat (2) @(posedge clk);
    #1 chk("test_off", {15'h0000, test_mode}, 16'h0000);
    login;
    chk("relogin", {15'h0000, test_mode}, 16'h0000);
    do_rst(2);
    login;
    chk("locked", {15'h0000, test_mode}, 16'h0000);
    rc("mode", 4'h8, 16'h0001);
    rd(4'hA, t);
    wr(4'hA, 16'h2222);
    rc("trace_lock", 4'hA, t);
    $display("mode test done");
    test_done;
  end
endmodule
`default_nettype wire

// ===== verilog/ssv_filter.sv
// Purpose: consecutive-count hold filter for one pad signal
// Assumes: pad already synchronous to clk
// Notes:   output changes only after input is stable N cycles
`timescale 1ns/10ps
`default_nettype none
module ssv_filter #(
  parameter int N = 4
) (
  input  wire logic clk,  // core clock
  input  wire logic rst,  // async reset
  input  wire logic d,    // raw pad level
  output logic      q     // filtered level
);
  logic [7:0] cnt_reg; // stability counter
  // count cycles of disagreement; glitches shorter than N are dropped
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= 8'h00;
      q       <= 1'b0;
    end
    else if (d == q)
      cnt_reg <= 8'h00;
    else if (cnt_reg >= 8'(N - 1))
    begin
      q       <= d;
      cnt_reg <= 8'h00;
    end
    else
      cnt_reg <= cnt_reg + 8'h01;
  end
endmodule
`default_nettype wire

// ===== verilog/ssv_pkg.sv
// Purpose: shared constants of the security supervisor
// Assumes: 20 MHz core clock, 16-bit register port
// Notes:   offsets are word indices on the plain register port
package ssv_pkg;
  // register offsets
  localparam logic [3:0] OFF_DET_STAT  = 4'h0; // latched detector events
  localparam logic [3:0] OFF_REACT     = 4'h1; // per-detector reaction
  localparam logic [3:0] OFF_VIOL_STAT = 4'h2; // access violation flags
  localparam logic [3:0] OFF_MPU_BASE  = 4'h4; // partition attrs 4..7
  localparam logic [3:0] OFF_MODE      = 4'h8; // test/normal mode
  localparam logic [3:0] OFF_SCR_KEY   = 4'h9; // static scramble key
  localparam logic [3:0] OFF_TRACE     = 4'hA; // traceability word
  // reset values
  localparam logic [6:0]  REACT_RST    = 7'h4F; // env, light and glitch reset
  localparam logic [3:0]  MPU_RST      = 4'h0;  // no user access
  localparam logic [15:0] SCR_KEY_RST  = 16'hA5C3;
  // detector bit positions
  localparam int DET_FREQ   = 0;
  localparam int DET_VOLT   = 1;
  localparam int DET_TEMP   = 2;
  localparam int DET_LIGHT  = 3;
  localparam int DET_INSUL  = 4;
  localparam int DET_SHIELD = 5;
  localparam int DET_GLITCH = 6;
  // violation bit positions
  localparam int VIO_INVAL  = 0;
  localparam int VIO_EXEC   = 1;
  localparam int VIO_PROHIB = 2;
  localparam int VIO_PRIV   = 3;
  // mpu attribute bit positions
  localparam int ATTR_UR = 0;
  localparam int ATTR_UW = 1;
  localparam int ATTR_UX = 2;
  // filter timing
  localparam int CLK_HZ          = 20000000;
  localparam int RST_FILT_NS     = 200;
  localparam int RST_FILT_CYC    = (RST_FILT_NS * (CLK_HZ / 1000000)
                                    + 999) / 1000;
  localparam int CLK_MIN_PER_CYC = 2; // pad clock edges closer are dropped
  // test password, arbitrary value
  localparam logic [15:0] TEST_PWD = 16'h5A17;
  typedef enum logic [1:0] {SSV_TLOCKED, SSV_TAUTH, SSV_TOPEN} ssv_test_e;
endpackage

// ===== verilog/ssv_top.sv
// Purpose: security supervisor: detectors, filters, access guard, mode
// Assumes: one clock; register port read data one cycle after strobe
// Notes:   cipher internals are outside this block; the random source is a local lfsr
`timescale 1ns/10ps
`default_nettype none
module ssv_top #(
  parameter int AW = 16,  // cpu address width
  parameter int NP = 4    // memory partitions
) (
  input  wire logic          clk,        // core clock
  input  wire logic          rst,        // power-on reset
  input  wire logic [6:0]    det_evt,    // detector event levels
  input  wire logic          pad_clk,    // external clock pad
  input  wire logic          pad_rst,    // external reset pad
  input  wire logic [3:0]    reg_addr,   // register index
  input  wire logic [15:0]   reg_wdata,  // register write data
  input  wire logic          reg_wr,     // register write strobe
  input  wire logic          reg_rd,     // register read strobe
  input  wire logic          cpu_priv,   // cpu in privilege mode
  output logic      [15:0]   reg_rdata,  // register read data
  input  wire logic          bus_req,    // cpu bus access
  input  wire logic          bus_fetch,  // access is instruction fetch
  input  wire logic          bus_write,  // access is a write
  input  wire logic [AW-1:0] bus_addr,   // plain cpu address
  input  wire logic [15:0]   bus_wdata,  // plain cpu write data
  output logic      [AW-1:0] mem_addr,   // scrambled address
  output logic      [15:0]   mem_wdata,  // scrambled, masked data
  output logic               mem_en,     // access allowed to memory
  output logic               fiq,        // fast interrupt pulse
  output logic               chip_rst,   // chip reset request
  output logic               clk_pad_f,  // filtered pad clock
  output logic               rst_pad_f,  // filtered pad reset
  output logic               clk_slow,   // variable internal clock en
  output logic               cur_noise,  // random current enable
  output logic               wait_ins,   // random wait request
  input  wire logic          nv_locked,  // lock bit from nv storage
  output logic               nv_lock_wr, // burn the lock bit
  input  wire logic          tst_valid,  // tester word valid
  input  wire logic [15:0]   tst_data,   // tester word
  output logic               test_mode   // test functions available
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [6:0]    det_stat_reg;          // latched detector events
  logic [6:0]    react_reg;             // 1 = reset, 0 = flag; bits 0-2 and 6 always reset
  logic [3:0]    viol_reg;              // access violation flags
  logic [3:0]    mpu_reg [NP];          // partition user attributes
  logic [15:0]   key_reg;               // static scramble key
  logic [15:0]   trace_reg;             // traceability word
  logic [15:0]   lfsr_reg;              // dynamic mask source
  logic          locked_reg;            // device in normal mode
  logic          lock_smp_reg;          // lock sampled after reset
  ssv_pkg::ssv_test_e tst_reg;          // test access state
  logic [1:0]    cper_reg;              // pad clock edge spacing
  logic          pclk_d_reg;            // previous rate-checked pad clock
  logic          wr_ok;                 // privileged register write
  logic          rd_ok;                 // privileged register read
  logic [6:0]    rst_evt;               // events that reset chip
  logic [1:0]    part;                  // partition of address
  logic [3:0]    attr;                  // its attributes
  logic          inval;                 // address beyond map
  logic          exec_bad;              // fetch not allowed
  logic          prohib;                // data access not allowed
  logic          clk_f_raw;             // pad clock after rate check
  logic [15:0]   wd_rev;                // bit-reversed write data

  // security registers only for privilege mode
  assign wr_ok = reg_wr && cpu_priv;
  assign rd_ok = reg_rd && cpu_priv;

  ////////////////////////////////////////////////////////////////////////
  // detectors: the detector path has no enable, only the reaction moves
  assign rst_evt = det_evt & (react_reg
                 | (7'h01 << ssv_pkg::DET_FREQ)
                 | (7'h01 << ssv_pkg::DET_VOLT)
                 | (7'h01 << ssv_pkg::DET_TEMP)
                 | (7'h01 << ssv_pkg::DET_GLITCH));

  // sticky event latch; a new event beats a same-cycle clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      det_stat_reg <= 7'h00;
    else if (wr_ok && reg_addr == ssv_pkg::OFF_DET_STAT)
      det_stat_reg <= (det_stat_reg & ~reg_wdata[6:0])
                      | det_evt;
    else
      det_stat_reg <= det_stat_reg | det_evt;
  end

  // reset reaction goes straight to the reset output next edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      chip_rst <= 1'b0;
    else
      chip_rst <= |rst_evt || rst_pad_f;
  end

  // reaction selection, one bit per detector
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      react_reg <= ssv_pkg::REACT_RST;
    else if (wr_ok && reg_addr == ssv_pkg::OFF_REACT)
      react_reg <= reg_wdata[6:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // pad filters: reset by stability, clock by minimum edge spacing
  ssv_filter #(.N(ssv_pkg::RST_FILT_CYC)) u_rst_filt (
    .clk (clk),
    .rst (rst),
    .d   (pad_rst),
    .q   (rst_pad_f)
  );

  // pad clock edges arriving too soon are suppressed (too fast)
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cper_reg   <= 2'h0;
      pclk_d_reg <= 1'b0;
    end
    else
    begin
      pclk_d_reg <= clk_f_raw;
      if (clk_f_raw != pclk_d_reg)
        cper_reg <= 2'h0;
      else if (cper_reg != 2'h3)
        cper_reg <= cper_reg + 2'h1;
    end
  end
  assign clk_f_raw = (cper_reg >= 2'(ssv_pkg::CLK_MIN_PER_CYC - 1))
                     ? pad_clk : pclk_d_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      clk_pad_f <= 1'b0;
    else
      clk_pad_f <= clk_f_raw;
  end

  ////////////////////////////////////////////////////////////////////////
  // memory protection: top address bits pick the partition
  assign part     = bus_addr[AW-1 -: 2];
  assign attr     = mpu_reg[part];
  assign inval    = bus_addr[AW-1 -: 2] == 2'h3 && bus_addr[AW-3];
  assign exec_bad = bus_fetch && !cpu_priv
                    && !attr[ssv_pkg::ATTR_UX];
  assign prohib   = !bus_fetch && !cpu_priv &&
                    !(bus_write ? attr[ssv_pkg::ATTR_UW]
                                : attr[ssv_pkg::ATTR_UR]);

  // partition attributes, privileged writes only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NP; i++)
        mpu_reg[i] <= ssv_pkg::MPU_RST;
    end
    else if (wr_ok && reg_addr[3:2] == ssv_pkg::OFF_MPU_BASE[3:2])
      mpu_reg[reg_addr[1:0]] <= reg_wdata[3:0];
  end

  // violation flags, sticky, set wins over clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      viol_reg <= 4'h0;
    else
    begin
      logic [3:0] v;
      v = '0;
      v[ssv_pkg::VIO_INVAL]  = bus_req && inval;
      v[ssv_pkg::VIO_EXEC]   = bus_req && exec_bad;
      v[ssv_pkg::VIO_PROHIB] = bus_req && prohib;
      v[ssv_pkg::VIO_PRIV]   = (reg_wr || reg_rd) && !cpu_priv;
      if (wr_ok && reg_addr == ssv_pkg::OFF_VIOL_STAT)
        viol_reg <= (viol_reg & ~reg_wdata[3:0]) | v;
      else
        viol_reg <= viol_reg | v;
    end
  end

  // fast interrupt on invalid address, bad fetch or tamper flag
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fiq <= 1'b0;
    else
      fiq <= (bus_req && (inval || exec_bad))
             || |(det_evt & ~rst_evt);
  end

  ////////////////////////////////////////////////////////////////////////
  // scrambling: fixed key xor on address and data; data also bit reversed and given a moving mask
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      lfsr_reg <= 16'hACE1;
    else
      lfsr_reg <= {lfsr_reg[14:0],
                   lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12]
                   ^ lfsr_reg[10]};
  end

  assign wd_rev = {<<{bus_wdata}};

  // trapped accesses never reach memory
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mem_en    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= 16'h0000;
    end
    else
    begin
      mem_en    <= bus_req && !inval && !exec_bad
                   && !prohib;
      mem_addr  <= bus_addr ^ key_reg[AW-1:0];
      mem_wdata <= wd_rev ^ key_reg
                   ^ lfsr_reg;
    end
  end

  // desynchronisation enables from the same random source
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      clk_slow  <= 1'b0;
      cur_noise <= 1'b0;
      wait_ins  <= 1'b0;
    end
    else
    begin
      clk_slow  <= lfsr_reg[0];
      cur_noise <= lfsr_reg[5];
      wait_ins  <= lfsr_reg[9] & lfsr_reg[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // test mode: lock sampled once after reset release, never cleared
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lock_smp_reg <= 1'b0;
      locked_reg   <= 1'b1;                     // safe until sampled
    end
    else if (!lock_smp_reg)
    begin
      lock_smp_reg <= 1'b1;
      locked_reg   <= nv_locked;
    end
    else if (tst_reg == ssv_pkg::SSV_TOPEN && wr_ok
             && reg_addr == ssv_pkg::OFF_MODE && reg_wdata[0])
      locked_reg <= 1'b1;
  end

  // test access fsm; commands only decoded once lock is known
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tst_reg <= ssv_pkg::SSV_TLOCKED;
    else if (!lock_smp_reg || locked_reg)
      tst_reg <= ssv_pkg::SSV_TLOCKED;
    else
      case (tst_reg)
        ssv_pkg::SSV_TLOCKED: if (tst_valid) tst_reg <= ssv_pkg::SSV_TAUTH;
        ssv_pkg::SSV_TAUTH:   if (tst_valid)
                       tst_reg <= (tst_data == ssv_pkg::TEST_PWD)
                         ? ssv_pkg::SSV_TOPEN
                         : ssv_pkg::SSV_TLOCKED;
        ssv_pkg::SSV_TOPEN:   tst_reg <= ssv_pkg::SSV_TOPEN;
        default:              tst_reg <= ssv_pkg::SSV_TLOCKED;
      endcase
  end

  // nv lock burn and visible test mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      test_mode  <= 1'b0;
      nv_lock_wr <= 1'b0;
    end
    else
    begin
      test_mode  <= tst_reg == ssv_pkg::SSV_TOPEN && !locked_reg;
      // only the first burn request pulses, even for back-to-back writes
      nv_lock_wr <= tst_reg == ssv_pkg::SSV_TOPEN && !locked_reg && wr_ok
                    && reg_addr == ssv_pkg::OFF_MODE
                    && reg_wdata[0];
    end
  end

  // scramble key and traceability word
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      key_reg   <= ssv_pkg::SCR_KEY_RST;
      trace_reg <= 16'h0000;
    end
    else
    begin
      if (wr_ok && test_mode && reg_addr == ssv_pkg::OFF_SCR_KEY)
        key_reg <= reg_wdata;
      if (wr_ok && test_mode && reg_addr == ssv_pkg::OFF_TRACE)
        trace_reg <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port; refused or unmapped reads return zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (!rd_ok)
      reg_rdata <= 16'h0000;
    else
      case (reg_addr)
        ssv_pkg::OFF_DET_STAT:  reg_rdata <= {9'h000, det_stat_reg};
        ssv_pkg::OFF_REACT:     reg_rdata <= {9'h000, react_reg};
        ssv_pkg::OFF_VIOL_STAT: reg_rdata <= {12'h000, viol_reg};
        4'h4, 4'h5, 4'h6, 4'h7:
          reg_rdata <= {12'h000, mpu_reg[reg_addr[1:0]]};
        ssv_pkg::OFF_MODE:
          reg_rdata <= {14'h0000, test_mode, locked_reg};
        ssv_pkg::OFF_TRACE:     reg_rdata <= trace_reg;
        default:                reg_rdata <= 16'h0000;
      endcase
  end
endmodule
`default_nettype wire
